// ==== design/wdtu_defs.vh ====
`ifndef WDTU_DEFS_VH
`define WDTU_DEFS_VH

// ----------------------------------------
// counter and prescaler
// ----------------------------------------
`define WDTU_CNT_W 16
`define WDTU_PRE_W 14
`define WDTU_PRE_SLOW 14'h3FFF
`define WDTU_PRE_FAST 14'h00FF
`define WDTU_ALL_ONES 16'hFFFF
`define WDTU_CNT_ZERO 16'h0000
`define WDTU_CNT_ONE 16'h0001
`define WDTU_PRE_ZERO 14'h0000
`define WDTU_PRE_ONE 14'h0001

// ----------------------------------------
// reset defaults: 6.5 ms at 10 MHz
// slow ratio 16384 -> 1.6384 ms per tick, 4 ticks to overflow
// ----------------------------------------
`define WDTU_RST_SEL_FAST 1'b0
`define WDTU_RST_RELOAD 16'hFFFC

`endif

// ==== design/wdtu_prescaler.v ====
`timescale 1ns/10ps
`include "wdtu_defs.vh"

module wdtu_prescaler (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // control
  input wire run,
  input wire clear,
  input wire sel_fast,
  // tick
  output wire tick
);

  reg [`WDTU_PRE_W-1:0] pre_reg;
  reg [`WDTU_PRE_W-1:0] pre_next;
  wire [`WDTU_PRE_W-1:0] pre_end;

  // ----------------------------------------
  // ratio select
  // ----------------------------------------
  // (R05) ratio 16384 or 256
  assign pre_end = sel_fast ? `WDTU_PRE_FAST : `WDTU_PRE_SLOW;
  assign tick = run && !clear && (pre_reg >= pre_end);

  always @* begin
    pre_next = pre_reg;
    // (R07) clear on service
    if (clear || tick) begin
      pre_next = `WDTU_PRE_ZERO;
    end else if (run) begin
      pre_next = pre_reg + `WDTU_PRE_ONE;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      pre_reg <= {`WDTU_PRE_W{1'b0}};
    end else begin
      pre_reg <= pre_next;
    end
  end

endmodule

// ==== design/wdtu_watchdog_timer_unit.v ====
// Function
// (R01) enabled and running after application reset
// (R02) disable/enable instructions stop/restart the watchdog
// (R03) software services before overflow
// (R04) overflow: prewarning first, then reset request
// (R05) 16-bit counter, prescaler 16384 or 256
// (R06) counter loads from programmable reload value
// (R07) service reloads counter, clears prescaler
// (R08) reset defaults give 6.5 ms at 10 MHz
// (R09) count up, overflow past all-ones, sticky prewarning
`timescale 1ns/10ps
`include "wdtu_defs.vh"

module wdtu_watchdog_timer_unit (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // instruction strobes
  input wire watchdog_service_instr,
  input wire watchdog_disable_instr,
  input wire watchdog_enable_instr,
  // configuration
  input wire [`WDTU_CNT_W-1:0] watchdog_reload_value,
  input wire reload_value_wr,
  input wire sel_fast_in,
  input wire sel_fast_wr,
  input wire prewarn_clear,
  // status
  output reg [`WDTU_CNT_W-1:0] count_out,
  output reg enabled_out,
  output reg prewarn_irq,
  output reg reset_request
);

  // ----------------------------------------
  // fault sequence codes
  // ----------------------------------------
  localparam [1:0] SEQ_ARMED = 2'b00;
  localparam [1:0] SEQ_WARNED = 2'b01;
  localparam [1:0] SEQ_FAULT = 2'b10;

  // ----------------------------------------
  // internal state
  // ----------------------------------------
  reg [`WDTU_CNT_W-1:0] reload_reg;
  reg [`WDTU_CNT_W-1:0] reload_next;
  reg sel_fast_reg;
  reg sel_fast_next;
  reg [1:0] seq_reg;
  reg [1:0] seq_next;
  reg enabled_next;
  reg [`WDTU_CNT_W-1:0] cnt_next;
  reg prewarn_next;
  reg reset_request_next;
  wire tick;
  wire service;
  wire at_top;
  wire overflow;
  wire first_overflow;
  wire second_overflow;
  wire [`WDTU_CNT_W-1:0] cnt_inc;

  // ----------------------------------------
  // strobe decode
  // ----------------------------------------
  assign service = watchdog_service_instr;
  assign at_top = (count_out == `WDTU_ALL_ONES);
  // (R09) overflow leaves all-ones
  assign overflow = tick && at_top;
  assign first_overflow = overflow && (seq_reg == SEQ_ARMED);
  assign second_overflow = overflow && (seq_reg == SEQ_WARNED);
  // (R09) count up by one
  assign cnt_inc = count_out + `WDTU_CNT_ONE;

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  // (R07) service clears prescaler
  wdtu_prescaler u_pre (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(enabled_out),
    .clear(service),
    .sel_fast(sel_fast_reg),
    .tick(tick)
  );

  // ----------------------------------------
  // configuration next values
  // ----------------------------------------
  always @* begin
    reload_next = reload_reg;
    sel_fast_next = sel_fast_reg;
    // (R06) programmable reload value
    if (reload_value_wr) begin
      reload_next = watchdog_reload_value;
    end
    // (R05) ratio select write
    if (sel_fast_wr) begin
      sel_fast_next = sel_fast_in;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      // (R08) default interval values
      reload_reg <= `WDTU_RST_RELOAD;
      sel_fast_reg <= `WDTU_RST_SEL_FAST;
    end else begin
      reload_reg <= reload_next;
      sel_fast_reg <= sel_fast_next;
    end
  end

  // ----------------------------------------
  // run control
  // ----------------------------------------
  always @* begin
    enabled_next = enabled_out;
    // (R02) disable wins over enable
    if (watchdog_disable_instr) begin
      enabled_next = 1'b0;
    end else if (watchdog_enable_instr) begin
      enabled_next = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      // (R01) enabled after reset
      enabled_out <= 1'b1;
    end else begin
      enabled_out <= enabled_next;
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always @* begin
    cnt_next = count_out;
    // (R07) service reloads counter
    if (service) begin
      cnt_next = reload_reg;
    end else if (overflow) begin
      // (R06) overflow reloads counter
      cnt_next = reload_reg;
    end else if (tick) begin
      // (R09) count up from reload
      cnt_next = cnt_inc;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      // (R08) default start count
      count_out <= `WDTU_RST_RELOAD;
    end else begin
      count_out <= cnt_next;
    end
  end

  // ----------------------------------------
  // fault sequence
  // ----------------------------------------
  always @* begin
    seq_next = seq_reg;
    case (seq_reg)
      SEQ_ARMED: begin
        // (R04) first overflow warns
        if (overflow) begin
          seq_next = SEQ_WARNED;
        end
      end
      SEQ_WARNED: begin
        // (R04) second overflow requests reset
        if (overflow) begin
          seq_next = SEQ_FAULT;
        end else if (service) begin
          seq_next = SEQ_ARMED;
        end
      end
      SEQ_FAULT: begin
        seq_next = SEQ_FAULT;
      end
      default: begin
        seq_next = SEQ_ARMED;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      seq_reg <= SEQ_ARMED;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // ----------------------------------------
  // prewarning flag
  // ----------------------------------------
  always @* begin
    prewarn_next = prewarn_irq;
    // (R09) sticky prewarning, set wins
    if (first_overflow) begin
      prewarn_next = 1'b1;
    end else if (prewarn_clear) begin
      prewarn_next = 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      prewarn_irq <= 1'b0;
    end else begin
      prewarn_irq <= prewarn_next;
    end
  end

  // ----------------------------------------
  // reset request
  // ----------------------------------------
  always @* begin
    reset_request_next = reset_request;
    // (R04) request only after prewarning
    if (second_overflow) begin
      reset_request_next = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      reset_request <= 1'b0;
    end else begin
      reset_request <= reset_request_next;
    end
  end

endmodule

// ==== tb/wdtu_chk_assertions.sv ====
`timescale 1ns/10ps
module wdtu_chk (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // inputs watched
  input wire watchdog_service_instr,
  input wire watchdog_disable_instr,
  input wire watchdog_enable_instr,
  input wire [15:0] watchdog_reload_value,
  input wire reload_value_wr,
  input wire prewarn_clear,
  // status
  input wire [15:0] count_out,
  input wire enabled_out,
  input wire prewarn_irq,
  input wire reset_request
);
  reg [15:0] rel_reg;
  reg [15:0] cyc_reg;
  reg seen_reg;
  always @(posedge clk_sys) begin
    if (reset) begin
      rel_reg <= 16'hFFFC;
      seen_reg <= 1'b0;
      cyc_reg <= 16'h0000;
    end else begin
      if (reload_value_wr) rel_reg <= watchdog_reload_value;
      if (prewarn_irq) seen_reg <= 1'b1;
      if ($changed(count_out) || watchdog_service_instr) begin
        cyc_reg <= 16'h0000;
      end else if (cyc_reg != 16'hFFFF) begin
        cyc_reg <= cyc_reg + 16'h0001;
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_rst_state: assert property (disable iff (1'b0)
    $fell(reset) |-> enabled_out && count_out == 16'hFFFC) else $error("rst");
  chk_dis_stop: assert property (watchdog_disable_instr |=>
    !enabled_out) else $error("dis");
  chk_en_run: assert property (watchdog_enable_instr &&
    !watchdog_disable_instr |=> enabled_out) else $error("ena");
  chk_dis_hold: assert property (!enabled_out &&
    !watchdog_service_instr |=> $stable(count_out)) else $error("hold");
  chk_srv_load: assert property (watchdog_service_instr |=>
    count_out == $past(rel_reg)) else $error("load");
  chk_cnt_step: assert property ($changed(count_out) &&
    !$past(watchdog_service_instr) && !$past(reset) |-> count_out ==
    ($past(count_out) == 16'hFFFF ? $past(rel_reg) : $past(count_out) +
    16'h0001)) else $error("step");
  chk_tick_gap: assert property ($changed(count_out) &&
    !$past(watchdog_service_instr) && !$past(reset) |-> cyc_reg >= 16'h00FA)
    else $error("gap");
  chk_warn_src: assert property ($rose(prewarn_irq) |->
    $past(count_out) == 16'hFFFF || $past(count_out, 2) == 16'hFFFF)
    else $error("warn");
  chk_warn_keep: assert property (prewarn_irq && !prewarn_clear |=>
    prewarn_irq) else $error("sticky");
  chk_req_after: assert property ($rose(reset_request) |->
    seen_reg) else $error("order");
  chk_req_keep: assert property (reset_request |=>
    reset_request) else $error("req");
  cover property ($rose(prewarn_irq));
  cover property ($rose(reset_request));
  cover property (watchdog_disable_instr ##1 !enabled_out);
endmodule
bind wdtu_watchdog_timer_unit wdtu_chk i_chk (.clk_sys, .reset,
  .watchdog_service_instr, .watchdog_disable_instr, .watchdog_enable_instr,
  .watchdog_reload_value, .reload_value_wr, .prewarn_clear, .count_out,
  .enabled_out, .prewarn_irq, .reset_request);

// ==== tb/wdtu_watchdog_timer_unit_tb.sv ====
`timescale 1ns/10ps
module wdtu_watchdog_timer_unit_tb;
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg srv = 1'b0, dis = 1'b0, ena = 1'b0, rwr = 1'b0;
  reg sfi = 1'b0, swr = 1'b0, pclr = 1'b0;
  reg [15:0] rel = 16'h0000;
  wire [15:0] cnt;
  wire en, warn, req;
  wire [15:0] st = {13'h0000, en, warn, req};
  integer failures = 0, total_checks = 0, i, n;
  always #2 clk_sys = ~clk_sys;
  wdtu_watchdog_timer_unit i_dut (.clk_sys(clk_sys), .reset(reset),
    .watchdog_service_instr(srv), .watchdog_disable_instr(dis),
    .watchdog_enable_instr(ena), .watchdog_reload_value(rel),
    .reload_value_wr(rwr), .sel_fast_in(sfi), .sel_fast_wr(swr),
    .prewarn_clear(pclr), .count_out(cnt), .enabled_out(en),
    .prewarn_irq(warn), .reset_request(req));
  task tk(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_cyc(input [31:0] got, input [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task serve;
    srv = 1'b1;
    tk(1);
    srv = 1'b0;
  endtask
  task wait_st(input [15:0] exp);
    for (i = 0; i < 300 && st !== exp; i = i + 1) tk(1);
    cmp(st, exp);
    if (i == 300) end_sim;
  endtask
  task t_service;
    {sfi, swr, rwr} = 3'h7;
    rel = 16'hFFF0;
    tk(1);
    {swr, rwr} = 2'h0;
    serve;
    cmp(cnt, 16'hFFF0);
    tk(200);
    serve;
    tk(250);
    cmp(cnt, 16'hFFF0);
    tk(10);
    cmp(cnt, 16'hFFF1);
    cmp(st, 16'h0004);
  endtask
  task t_disable;
    dis = 1'b1;
    tk(1);
    dis = 1'b0;
    tk(600);
    cmp(st, 16'h0000);
    cmp(cnt, 16'hFFF1);
    ena = 1'b1;
    tk(1);
    ena = 1'b0;
    cmp(st, 16'h0004);
  endtask
  task t_overflow;
    rel = 16'hFFFF;
    rwr = 1'b1;
    tk(1);
    rwr = 1'b0;
    serve;
    wait_st(16'h0006);
    pclr = 1'b1;
    tk(1);
    pclr = 1'b0;
    cmp(st, 16'h0004);
    serve;
    wait_st(16'h0006);
    wait_st(16'h0007);
    pclr = 1'b1;
    tk(1);
    pclr = 1'b0;
    cmp(st, 16'h0005);
    cmp(cnt, 16'hFFFF);
  endtask
  task t_default;
    reset = 1'b1;
    tk(4);
    reset = 1'b0;
    cmp(cnt, 16'hFFFC);
    cmp(st, 16'h0004);
    n = 0;
    while (n < 70000 && warn !== 1'b1) begin
      tk(1);
      n = n + 1;
    end
    cmp_cyc(n, 32'h0001_0000);
    if (n == 70000) end_sim;
    cmp(st, 16'h0006);
    cmp(cnt, 16'hFFFC);
  endtask
  initial begin
    tk(4);
    reset = 1'b0;
    cmp(cnt, 16'hFFFC);
    cmp(st, 16'h0004);
    t_service;
    t_disable;
    t_overflow;
    t_default;
    end_sim;
  end
endmodule
